/* src/ref_ctrl_pkg.sv */
// Purpose: Shared constants for the frequency reference control
// Assumes: Percent values in tenths of a percent, 1000 = 100.0 %
// Notes:   Function codes are the contact input assignment codes
package ref_ctrl_pkg;
    // ========================================
    // Widths
    localparam int FREQ_W = 16;
    localparam int PCT_W  = 11;
    localparam int FSEL_W = 8;

    // ========================================
    // Contact input function codes
    localparam logic [FSEL_W-1:0] FN_RAMP_HOLD = 8'h0A;
    localparam logic [FSEL_W-1:0] FN_RAISE     = 8'h10;
    localparam logic [FSEL_W-1:0] FN_LOWER     = 8'h11;

    // ========================================
    // Reset values and percent full scale
    localparam logic             RETENTION_RST   = 1'b0;
    localparam logic [PCT_W-1:0] UPPER_LIMIT_RST = 11'h3E8;
    localparam logic [PCT_W-1:0] LOWER_LIMIT_RST = 11'h000;
    localparam logic [PCT_W-1:0] PCT_FULL_SCALE  = 11'h3E8;

    // ========================================
    // Timing
    localparam int CLK_MHZ          = 200;
    localparam int RAMP_TICK_NS     = 1000;
    localparam int RAMP_TICK_CYCLES = (RAMP_TICK_NS * CLK_MHZ + 999) / 1000;

    // Percent of maximum frequency to a frequency value
    function automatic logic [FREQ_W-1:0] pct_to_freq(input logic [FREQ_W-1:0] fmax,
                                                      input logic [PCT_W-1:0]  pct);
        logic [FREQ_W+PCT_W-1:0] prod;
        prod = fmax * pct;
        pct_to_freq = FREQ_W'(prod / PCT_FULL_SCALE);
    endfunction
endpackage

/* src/fn_if.sv */
// Purpose: Decoded contact input functions
// Assumes: Driven combinationally by the decoder
// Notes:   Levels are already synchronised
`timescale 1ns/1ps
interface fn_if;
    logic hold_assigned;
    logic up_assigned;
    logic down_assigned;
    logic hold_on;
    logic up_on;
    logic down_on;
    logic config_error;

    modport decoder (output hold_assigned, up_assigned, down_assigned,
                     output hold_on, up_on, down_on, config_error);
    modport user    (input hold_assigned, up_assigned, down_assigned,
                     input hold_on, up_on, down_on, config_error);
endinterface

/* src/input_function_decoder.sv */
// Purpose: Map contact inputs to ramp hold and raise/lower functions
// Assumes: Function selects are stable static configuration
// Notes:   Several inputs with one function are ORed
`timescale 1ns/1ps
module input_function_decoder #(
    parameter int N_INPUTS = 10
) (
    input  wire logic [N_INPUTS*ref_ctrl_pkg::FSEL_W-1:0] function_select,
    input  wire logic [N_INPUTS-1:0]                      contact_level,
    fn_if.decoder                                         fn
);
    // ========================================
    // Decode
    always_comb begin
        logic [ref_ctrl_pkg::FSEL_W-1:0] code;
        code = '0;
        fn.hold_assigned = 1'b0;
        fn.up_assigned   = 1'b0;
        fn.down_assigned = 1'b0;
        fn.hold_on       = 1'b0;
        fn.up_on         = 1'b0;
        fn.down_on       = 1'b0;
        for (int i = 0; i < N_INPUTS; i++) begin
            code = function_select[i*ref_ctrl_pkg::FSEL_W +: ref_ctrl_pkg::FSEL_W];
            if (code == ref_ctrl_pkg::FN_RAMP_HOLD) begin
                fn.hold_assigned = 1'b1;
                fn.hold_on       = fn.hold_on | contact_level[i];
            end
            if (code == ref_ctrl_pkg::FN_RAISE) begin
                fn.up_assigned = 1'b1;
                fn.up_on       = fn.up_on | contact_level[i];
            end
            if (code == ref_ctrl_pkg::FN_LOWER) begin
                fn.down_assigned = 1'b1;
                fn.down_on       = fn.down_on | contact_level[i];
            end
        end
        fn.config_error = (fn.up_assigned ^ fn.down_assigned)
                        | ((fn.up_assigned | fn.down_assigned) & fn.hold_assigned);
    end
endmodule

/* src/ramp_generator.sv */
// Purpose: Step output frequency toward a target at fixed tick rate
// Assumes: Steps are per tick, set from acceleration/deceleration times
// Notes:   Load overrides hold; hold freezes the output
`timescale 1ns/1ps
module ramp_generator #(
    parameter int TICK_CYCLES = ref_ctrl_pkg::RAMP_TICK_CYCLES
) (
    input  wire logic                            mclk,
    input  wire logic                            rst_n,
    input  wire logic [ref_ctrl_pkg::FREQ_W-1:0] target,
    input  wire logic [ref_ctrl_pkg::FREQ_W-1:0] accel_step,
    input  wire logic [ref_ctrl_pkg::FREQ_W-1:0] decel_step,
    input  wire logic                            hold,
    input  wire logic                            load,
    input  wire logic [ref_ctrl_pkg::FREQ_W-1:0] load_value,
    output logic      [ref_ctrl_pkg::FREQ_W-1:0] freq_reg
);
    localparam int CW = $clog2(TICK_CYCLES + 1);

    logic [CW-1:0] tick_cnt_reg;
    logic          tick;

    // ========================================
    // Tick prescaler
    assign tick = (tick_cnt_reg == CW'(TICK_CYCLES - 1));

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_reg <= '0;
        end else if (tick) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + CW'(1);
        end
    end

    // ========================================
    // Ramp, saturating at the target
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            freq_reg <= '0;
        end else if (load) begin
            freq_reg <= load_value;
        end else if (tick && !hold) begin
            if (target > freq_reg) begin
                freq_reg <= (target - freq_reg > accel_step) ? freq_reg + accel_step : target;
            end else if (target < freq_reg) begin
                freq_reg <= (freq_reg - target > decel_step) ? freq_reg - decel_step : target;
            end
        end
    end

    // ========================================
    // Checks
    property p_hold_freeze;
        @(posedge mclk) disable iff (!rst_n)
        hold && !load |=> freq_reg == $past(freq_reg);
    endproperty
    a_hold_freeze: assert property (p_hold_freeze) else $error("ramp moved while held");

    property p_resume;
        @(posedge mclk) disable iff (!rst_n)
        tick && !hold && !load && (target > freq_reg) && (accel_step != '0)
            |=> freq_reg > $past(freq_reg);
    endproperty
    a_resume: assert property (p_resume) else $error("ramp did not resume");
endmodule

/* src/ramp_hold_updown_ref.sv */
// Purpose: Ramp hold and raise/lower frequency reference control
// Assumes: Contacts and run are pins; settings come from local logic
// Notes:   Stored reference persists through an external memory port
//
// Function
// - Hold input freezes ramp, stores output frequency
// - Hold release resumes ramping toward reference
// - Retention setting 0/1, default 0, locked running
// - Retention on writes held value to memory
// - Retention off: run during hold gives zero
// - Codes 10/11 are raise and lower
// - Only one of raise/lower flags error
// - Raise/lower plus hold flags error
// - Lower bound is largest of analog, limits
// - Run in raise/lower accelerates to lower bound
// - Raise/lower disables preset speed selection
// - Retained raise/lower reference restored on run
// - Raise/lower edge while running clears stored value
// - Ramp rates set by accel/decel steps
`timescale 1ns/1ps
module ramp_hold_updown_ref #(
    parameter int N_INPUTS    = 10,
    parameter int TICK_CYCLES = ref_ctrl_pkg::RAMP_TICK_CYCLES
) (
    input  wire logic                                     mclk,
    input  wire logic                                     rst_n,
    input  wire logic [N_INPUTS-1:0]                      contact_in,
    input  wire logic                                     run_in,
    input  wire logic [N_INPUTS*ref_ctrl_pkg::FSEL_W-1:0] input_function_select,
    input  wire logic                                     reference_retention_select,
    input  wire logic [ref_ctrl_pkg::PCT_W-1:0]           reference_upper_limit,
    input  wire logic [ref_ctrl_pkg::PCT_W-1:0]           reference_lower_limit,
    input  wire logic [ref_ctrl_pkg::PCT_W-1:0]           master_reference_lower_limit,
    input  wire logic [ref_ctrl_pkg::FREQ_W-1:0]          maximum_output_frequency,
    input  wire logic [ref_ctrl_pkg::FREQ_W-1:0]          analog_reference_input,
    input  wire logic [ref_ctrl_pkg::FREQ_W-1:0]          master_reference,
    input  wire logic                                     preset_step_select,
    input  wire logic [ref_ctrl_pkg::FREQ_W-1:0]          first_preset_reference,
    input  wire logic [ref_ctrl_pkg::FREQ_W-1:0]          accel_step,
    input  wire logic [ref_ctrl_pkg::FREQ_W-1:0]          decel_step,
    input  wire logic [ref_ctrl_pkg::FREQ_W-1:0]          held_reference_memory_in,
    output logic      [ref_ctrl_pkg::FREQ_W-1:0]          output_frequency,
    output logic      [ref_ctrl_pkg::FREQ_W-1:0]          reference_monitor,
    output logic                                          invalid_input_selection_error,
    output logic                                          ramp_hold_active,
    output logic                                          held_reference_memory_write,
    output logic      [ref_ctrl_pkg::FREQ_W-1:0]          held_reference_memory_out
);
    localparam int FW = ref_ctrl_pkg::FREQ_W;
    localparam int PW = ref_ctrl_pkg::PCT_W;

    function automatic logic [FW-1:0] max_f(input logic [FW-1:0] a, input logic [FW-1:0] b);
        max_f = (a > b) ? a : b;
    endfunction

    function automatic logic [FW-1:0] min_f(input logic [FW-1:0] a, input logic [FW-1:0] b);
        min_f = (a < b) ? a : b;
    endfunction

    // ========================================
    // Declarations
    logic [N_INPUTS-1:0] contact_meta_reg;
    logic [N_INPUTS-1:0] contact_sync_reg;
    logic                run_meta_reg;
    logic                run_sync_reg;
    logic                run_prev_reg;
    logic                hold_prev_reg;
    logic                up_prev_reg;
    logic                down_prev_reg;
    logic                moving_prev_reg;
    logic                restored_reg;
    logic                retention_reg;
    logic [PW-1:0]       upper_pct_reg;
    logic [PW-1:0]       lower_pct_reg;
    logic [PW-1:0]       master_lower_pct_reg;
    logic [FW-1:0]       stored_ref_reg;
    logic [FW-1:0]       stored_next;
    logic                stored_we;
    logic                hold_mode;
    logic                updown_mode;
    logic                retain_active;
    logic                run_rise;
    logic                hold_rise;
    logic                up_rise;
    logic                down_rise;
    logic                moving;
    logic                use_preset;
    logic [FW-1:0]       upper_freq;
    logic [FW-1:0]       lower_freq;
    logic [FW-1:0]       ref_target;
    logic                ramp_hold;
    logic                ramp_load;
    logic [FW-1:0]       load_value;
    logic                error_reg;
    logic                hold_active_reg;
    logic [FW-1:0]       monitor_reg;
    logic                mem_write_reg;
    logic [FW-1:0]       mem_value_reg;

    fn_if fn ();

    // ========================================
    // Pin synchronisers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            contact_meta_reg <= '0;
            contact_sync_reg <= '0;
            run_meta_reg     <= 1'b0;
            run_sync_reg     <= 1'b0;
        end else begin
            contact_meta_reg <= contact_in;
            contact_sync_reg <= contact_meta_reg;
            run_meta_reg     <= run_in;
            run_sync_reg     <= run_meta_reg;
        end
    end

    input_function_decoder #(
        .N_INPUTS (N_INPUTS)
    ) u_decoder (
        .function_select (input_function_select),
        .contact_level   (contact_sync_reg),
        .fn              (fn.decoder)
    );

    // ========================================
    // Edge history
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            run_prev_reg    <= 1'b0;
            hold_prev_reg   <= 1'b0;
            up_prev_reg     <= 1'b0;
            down_prev_reg   <= 1'b0;
            moving_prev_reg <= 1'b0;
        end else begin
            run_prev_reg    <= run_sync_reg;
            hold_prev_reg   <= fn.hold_on;
            up_prev_reg     <= fn.up_on;
            down_prev_reg   <= fn.down_on;
            moving_prev_reg <= moving;
        end
    end

    assign run_rise  = run_sync_reg & ~run_prev_reg;
    assign hold_rise = fn.hold_on & ~hold_prev_reg;
    assign up_rise   = fn.up_on & ~up_prev_reg;
    assign down_rise = fn.down_on & ~down_prev_reg;
    assign moving    = fn.up_on ^ fn.down_on;

    // ========================================
    // Settings, taken only while stopped
    // Run is the terminal run input, so raise/lower always sees it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            retention_reg        <= ref_ctrl_pkg::RETENTION_RST;
            upper_pct_reg        <= ref_ctrl_pkg::UPPER_LIMIT_RST;
            lower_pct_reg        <= ref_ctrl_pkg::LOWER_LIMIT_RST;
            master_lower_pct_reg <= ref_ctrl_pkg::LOWER_LIMIT_RST;
        end else if (!run_sync_reg) begin
            retention_reg        <= reference_retention_select;
            upper_pct_reg        <= reference_upper_limit;
            lower_pct_reg        <= reference_lower_limit;
            master_lower_pct_reg <= master_reference_lower_limit;
        end
    end

    assign hold_mode     = fn.hold_assigned & ~fn.config_error;
    assign updown_mode   = fn.up_assigned & fn.down_assigned & ~fn.config_error;
    assign retain_active = retention_reg & (hold_mode | updown_mode);
    assign use_preset    = preset_step_select & ~updown_mode;

    // ========================================
    // Limits
    assign upper_freq = ref_ctrl_pkg::pct_to_freq(maximum_output_frequency, upper_pct_reg);
    // Lower bound never above upper, so the clamp stays ordered
    assign lower_freq = min_f(upper_freq,
        max_f(analog_reference_input,
              max_f(ref_ctrl_pkg::pct_to_freq(maximum_output_frequency, lower_pct_reg),
                    ref_ctrl_pkg::pct_to_freq(maximum_output_frequency,
                                              master_lower_pct_reg))));

    // ========================================
    // Stored reference update
    always_comb begin
        stored_we   = 1'b0;
        stored_next = stored_ref_reg;
        if (hold_mode && hold_rise && run_sync_reg) begin
            stored_we   = 1'b1;
            stored_next = output_frequency;
        end else if (updown_mode && run_rise && !retain_active) begin
            stored_we   = 1'b1;
            stored_next = '0;
        end else if (updown_mode && run_sync_reg && (up_rise || down_rise)) begin
            stored_we   = 1'b1;
            stored_next = '0;
        end else if (updown_mode && run_sync_reg && moving_prev_reg && !moving) begin
            stored_we   = 1'b1;
            stored_next = output_frequency;
        end
    end

    // First cycle after reset pulls the retained value in
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            restored_reg   <= 1'b0;
            stored_ref_reg <= '0;
        end else if (!restored_reg) begin
            restored_reg   <= 1'b1;
            stored_ref_reg <= reference_retention_select ? held_reference_memory_in : '0;
        end else if (stored_we) begin
            stored_ref_reg <= stored_next;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mem_write_reg <= 1'b0;
            mem_value_reg <= '0;
        end else begin
            mem_write_reg <= restored_reg & stored_we & retain_active;
            mem_value_reg <= stored_next;
        end
    end

    // ========================================
    // Reference selection
    always_comb begin
        if (!run_sync_reg) begin
            ref_target = '0;
        end else if (updown_mode) begin
            if (fn.up_on && !fn.down_on) begin
                ref_target = upper_freq;
            end else if (fn.down_on && !fn.up_on) begin
                ref_target = lower_freq;
            end else begin
                ref_target = max_f(lower_freq, min_f(upper_freq, stored_ref_reg));
            end
        end else begin
            ref_target = min_f(upper_freq,
                use_preset ? first_preset_reference : master_reference);
        end
    end

    // Run with hold on: retained value or zero, then frozen
    always_comb begin
        ramp_load  = 1'b0;
        load_value = '0;
        if (run_rise && hold_mode && fn.hold_on) begin
            ramp_load  = 1'b1;
            load_value = retain_active ? min_f(upper_freq, stored_ref_reg) : '0;
        end
    end

    assign ramp_hold = hold_mode & fn.hold_on & run_sync_reg;

    ramp_generator #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_ramp (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .target     (ref_target),
        .accel_step (accel_step),
        .decel_step (decel_step),
        .hold       (ramp_hold),
        .load       (ramp_load),
        .load_value (load_value),
        .freq_reg   (output_frequency)
    );

    // ========================================
    // Status outputs
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            error_reg       <= 1'b0;
            hold_active_reg <= 1'b0;
            monitor_reg     <= '0;
        end else begin
            error_reg       <= fn.config_error;
            hold_active_reg <= ramp_hold;
            monitor_reg     <= ref_target;
        end
    end

    assign invalid_input_selection_error = error_reg;
    assign ramp_hold_active              = hold_active_reg;
    assign reference_monitor             = monitor_reg;
    assign held_reference_memory_write   = mem_write_reg;
    assign held_reference_memory_out     = mem_value_reg;

    // ========================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_hold_start;
        restored_reg && hold_mode && hold_rise && run_sync_reg;
    endsequence

    property p_hold_capture;
        s_hold_start |=> stored_ref_reg == $past(output_frequency);
    endproperty
    a_hold_capture: assert property (p_hold_capture) else $error("hold value not stored");

    property p_setting_locked;
        run_sync_reg |=> $stable(retention_reg);
    endproperty
    a_setting_locked: assert property (p_setting_locked) else $error("setting moved running");

    property p_mem_store;
        s_hold_start and retain_active
            |=> held_reference_memory_write && held_reference_memory_out == $past(output_frequency);
    endproperty
    a_mem_store: assert property (p_mem_store) else $error("held value not written");

    sequence s_run_in_hold;
        run_rise && hold_mode && fn.hold_on && !retain_active;
    endsequence

    property p_zero_on_run;
        s_run_in_hold |=> output_frequency == '0;
    endproperty
    a_zero_on_run: assert property (p_zero_on_run) else $error("run in hold not zero");

    property p_single_error;
        fn.up_assigned != fn.down_assigned |=> invalid_input_selection_error;
    endproperty
    a_single_error: assert property (p_single_error) else $error("lone raise/lower missed");

    property p_mix_error;
        (fn.up_assigned || fn.down_assigned) && fn.hold_assigned
            |=> invalid_input_selection_error;
    endproperty
    a_mix_error: assert property (p_mix_error) else $error("hold mix not flagged");

    property p_upper;
        ref_target <= upper_freq;
    endproperty
    a_upper: assert property (p_upper) else $error("reference above upper limit");

    property p_lower;
        run_sync_reg && updown_mode |-> ref_target >= lower_freq;
    endproperty
    a_lower: assert property (p_lower) else $error("reference below lower bound");

    sequence s_ud_start;
        restored_reg && updown_mode && run_rise && !retain_active
            ##1 run_sync_reg && !fn.up_on && !fn.down_on && updown_mode;
    endsequence

    property p_run_to_lower;
        s_ud_start |-> ref_target == lower_freq;
    endproperty
    a_run_to_lower: assert property (p_run_to_lower) else $error("run not to lower bound");

    property p_no_preset;
        updown_mode |-> !use_preset;
    endproperty
    a_no_preset: assert property (p_no_preset) else $error("preset used in raise/lower");

    property p_edge_clear;
        restored_reg && updown_mode && run_sync_reg && (up_rise || down_rise)
            |=> stored_ref_reg == '0;
    endproperty
    a_edge_clear: assert property (p_edge_clear) else $error("stored value not cleared");

    property p_steady;
        restored_reg && updown_mode && run_sync_reg && !run_rise && !moving
            && !moving_prev_reg && !up_rise && !down_rise
            |=> $stable(stored_ref_reg);
    endproperty
    a_steady: assert property (p_steady) else $error("reference moved while steady");
endmodule

/* verification/operator_model.sv */
// Purpose: Operator driving the contact and run pins
// Assumes: Contact 0 hold, 1 raise, 2 lower, rest open
// Notes:   Pins follow a command one edge later, like a relay
`timescale 1ns/1ps
module operator_model #(
    parameter int N = 10
) (
    input  wire logic         mclk,
    input  wire logic [3:0]   cmd,
    output logic      [N-1:0] contact = '0,
    output logic              run_pin = 1'b0
);
    // ========================================
    // Pins
    always @(posedge mclk) begin
        contact <= {{(N-3){1'b0}}, cmd[2:0]};
        run_pin <= cmd[3];
    end
endmodule

/* verification/ramp_hold_and_up_down_reference_tb_top.sv */
// Purpose: Self-checking bench for the reference control
// Assumes: Short ramp tick, full scale 1000 units
// Notes:   Seeded random references, corner cases by hand
`timescale 1ns/1ps
module ramp_hold_and_up_down_reference_tb_top;
    logic mclk = 1'b0, rst_n = 1'b0, ret = 1'b0, pre = 1'b0, wr_seen = 1'b0;
    logic [79:0] sel = '0;
    logic [3:0] cmd = '0;
    logic [9:0] ct;
    logic run_pin, err, hact, mwr;
    logic [10:0] upl = 11'h258, lol = 11'h0C8, mll = 11'h000;
    logic [15:0] mref = '0, ana = '0, fpr = 16'h0064, hmi = 16'h0123, ofr, mon, mout, frz;
    int seed = 72, n_fail = 0, n_tests = 0;
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) if (mwr === 1'b1) wr_seen <= 1'b1;
    operator_model #(.N(10)) op (.mclk(mclk), .cmd(cmd), .contact(ct), .run_pin(run_pin));
    ramp_hold_updown_ref #(.N_INPUTS(10), .TICK_CYCLES(2)) uut (
        .mclk(mclk), .rst_n(rst_n), .contact_in(ct), .run_in(run_pin),
        .input_function_select(sel), .reference_retention_select(ret),
        .reference_upper_limit(upl), .reference_lower_limit(lol),
        .master_reference_lower_limit(mll), .maximum_output_frequency(16'h03E8),
        .analog_reference_input(ana), .master_reference(mref),
        .preset_step_select(pre), .first_preset_reference(fpr),
        .accel_step(16'h000A), .decel_step(16'h000A), .held_reference_memory_in(hmi),
        .output_frequency(ofr), .reference_monitor(mon),
        .invalid_input_selection_error(err), .ramp_hold_active(hact),
        .held_reference_memory_write(mwr), .held_reference_memory_out(mout));
    // Upper limit in units: percent tenths of a 1000 full scale
    function automatic logic [15:0] lim(input logic [15:0] r);
        lim = (r > {5'h00, upl}) ? {5'h00, upl} : r;
    endfunction
    task automatic wc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("tests=%0d fails=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #50000;
        n_fail++;
        end_sim;
    end
    initial begin
        wc(16);
        rst_n <= 1'b1;
        wc(4);
        check({15'h0, err}, 16'h0000);
        sel <= 80'h1000; wc(4); check({15'h0, err}, 16'h0001);
        sel <= 80'h110000; wc(4); check({15'h0, err}, 16'h0001);
        sel <= 80'h11100A; wc(4); check({15'h0, err}, 16'h0001);
        sel <= 80'h111000; wc(4); check({15'h0, err}, 16'h0000);
        $display("config done");
        sel <= 80'h0A; ret <= 1'b1; mref <= 16'h012C + ($random(seed) & 16'h01FF);
        wc(4); cmd <= 4'h8; wc(30); cmd <= 4'h9; wc(6);
        check({15'h0, hact}, 16'h0001);
        frz = ofr; wc(20); check(ofr, frz);
        check(mout, frz); check({15'h0, wr_seen}, 16'h0001);
        cmd <= 4'h8; wc(250); check(ofr, lim(mref));
        $display("hold done");
        cmd <= 4'h0; wc(4); ret <= 1'b0; cmd <= 4'h1; wc(4); cmd <= 4'h9; wc(8);
        check(ofr, 16'h0000);
        $display("zero load done");
        cmd <= 4'h0; sel <= 80'h111000; ana <= 16'h012C; pre <= 1'b1; mll <= 11'h15E; wc(6);
        cmd <= 4'h8; wc(100); check(ofr, 16'h015E);
        cmd <= 4'hA; wc(150); check(ofr, {5'h00, upl});
        cmd <= 4'h8; wc(20); check(ofr, {5'h00, upl});
        cmd <= 4'hC; wc(150); check(ofr, 16'h015E);
        $display("raise lower done");
        cmd <= 4'h0; ret <= 1'b1; hmi <= 16'h0190 + ($random(seed) & 16'h00FF); wc(4);
        rst_n <= 1'b0; wc(4); rst_n <= 1'b1; wc(4);
        check(ofr, 16'h0000);
        cmd <= 4'h8; wc(150); check(ofr, lim(hmi));
        $display("retention done");
        cmd <= 4'h0; sel <= '0; fpr <= 16'h0064 + ($random(seed) & 16'h00FF); wc(6);
        cmd <= 4'h8; wc(250); check(ofr, lim(fpr));
        $display("preset done");
        end_sim;
    end
endmodule
